// ---- common/spi_master_defs.svh ----
// Bit positions, reset values and timing constants of the serial port.
`ifndef SPI_MASTER_DEFS_SVH
`define SPI_MASTER_DEFS_SVH

`define CTL_FLAG_BIT 7
`define CTL_MASTER_BIT 6
`define CTL_FAULT_BIT 5
`define CTL_SEL_HI_BIT 3
`define CTL_SEL_LO_BIT 2
`define CTL_ENABLE_BIT 0
`define CTL_RESET 8'h04
`define SCK_HALF_CYCLES 8'h02
`define BYTE_BITS 4'h8
`define FIFO_DEPTH 8

`endif

// ---- common/spi_master_pkg.sv ----
// Types shared by the serial port engine.
package spi_master_pkg;

  typedef enum logic [1:0] {
    SEL_THREE_WIRE,
    SEL_MULTI_MASTER,
    SEL_FOUR_WIRE
  } select_mode_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic sel_out;
    logic sel_oe;
  } serial_pins_s;

  typedef struct packed {
    logic transfer_complete_flag;
    logic master_enable_bit;
    logic mode_fault_flag;
    logic select_mode_hi;
    logic select_mode_lo;
    logic port_enable_bit;
  } control_s;

endpackage

// ---- core/byte_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  output logic [WIDTH-1:0] out_data, // head entry
  output logic out_valid, // not empty
  input wire logic out_ready // head taken
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  wire ptr_eq = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];

  assign in_ready = !(ptr_eq && (wr_ptr_ff[AW] != rd_ptr_ff[AW]));
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_wr);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_rd);
    end
  end

endmodule // byte_fifo

// ---- core/spi_master_engine.sv ----
// Master-mode engine of the serial peripheral port.
// Contract
// - Setting master_enable_bit together with port_enable_bit makes the port act as bus master.
// - A data register write in master mode goes to the transmit buffer.
// - With the shift register empty, the buffered byte loads and starts.
// - The started byte shifts out on MOSI while SCK is generated.
// - End of each byte sets transfer_complete_flag.
// - A set transfer_complete_flag raises an interrupt request if enabled.
// - The slave returns its bits on MISO during the same transfer.
// - Incoming bits enter the shift register most significant bit first.
// - A full received byte goes to the receive buffer for reads.
// - Select mode 01, the reset default, is multi-master with select input.
// - Low select input in multi-master clears enables and sets mode fault.
// - A set mode_fault_flag raises an interrupt request if enabled.
// - After a fault the port stays off until software re-enables it.
// - Select mode 00 is three-wire; the select pin is unused.
// - Select mode hi bit set is four-wire with select driven out.
// - In four-wire mode the select output follows select_mode_lo.
`timescale 1ns/1ps
`include "spi_master_defs.svh"
module spi_master_engine #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter logic [7:0] HALF_CYCLES = `SCK_HALF_CYCLES
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic ctl_wr, // control register write strobe
  input wire logic [7:0] ctl_wdata, // control register write value
  output logic [7:0] ctl_rdata, // control register contents
  input wire logic data_wr, // data register write strobe
  input wire logic [7:0] data_wdata, // byte to transmit
  output logic data_wr_ready, // transmit buffer can take a byte
  output logic [7:0] rx_data, // receive buffer
  input wire logic irq_enable, // interrupt enable for this port
  output logic irq, // interrupt request, level
  output logic sck, // serial clock out
  output logic sck_oe, // serial clock drive enable
  output logic mosi, // serial data out
  output logic mosi_oe, // serial data drive enable
  input wire logic miso, // serial data in
  input wire logic slave_select_in, // select pin level
  output logic slave_select_out, // select pin drive value
  output logic slave_select_oe // select pin drive enable
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial begin
    if (HALF_CYCLES == 8'h00) begin
      $error("spi_master_engine: HALF_CYCLES must be nonzero");
    end
    if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin
      $error("spi_master_engine: FIFO_DEPTH must be a power of two");
    end
  end

  // Occupancy needs one bit more than the FIFO index to tell full from empty.
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
  localparam logic [7:0] CTL_RESET_W = `CTL_RESET;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH
  } shift_state_e;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  spi_master_pkg::control_s ctl_ff;
  spi_master_pkg::control_s nxt_ctl;
  spi_master_pkg::serial_pins_s pins_ff;
  spi_master_pkg::serial_pins_s nxt_pins;
  spi_master_pkg::select_mode_e sel_mode;
  shift_state_e state_ff;
  shift_state_e nxt_state;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] rx_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic irq_ff;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic [LVL_W-1:0] level_ff;
  logic [LVL_W-1:0] nxt_level;
  logic data_wr_ready_ff;
  logic nxt_ready;
  logic [7:0] ctl_rdata_ff;
  logic drive_oe_ff;
  logic nxt_drive_oe;
  logic nxt_irq;
  logic tx_push;

  wire [7:0] nxt_ctl_bits = {nxt_ctl.transfer_complete_flag,
                             nxt_ctl.master_enable_bit,
                             nxt_ctl.mode_fault_flag,
                             1'b0,
                             nxt_ctl.select_mode_hi,
                             nxt_ctl.select_mode_lo,
                             1'b0,
                             nxt_ctl.port_enable_bit};

  wire master_on = ctl_ff.master_enable_bit && ctl_ff.port_enable_bit;

  assign sel_mode = ctl_ff.select_mode_hi ? spi_master_pkg::SEL_FOUR_WIRE :
                    ctl_ff.select_mode_lo ? spi_master_pkg::SEL_MULTI_MASTER :
                                            spi_master_pkg::SEL_THREE_WIRE;

  wire fault_hit = (sel_mode == spi_master_pkg::SEL_MULTI_MASTER) &&
                   master_on && !slave_select_in;

  wire half_done = div_ff == (HALF_CYCLES - 8'h01);
  wire last_bit = bit_cnt_ff == (`BYTE_BITS - 4'h1);
  wire load_byte = (state_ff == ST_IDLE) && fifo_valid && master_on &&
                   !fault_hit;
  wire byte_done = (state_ff == ST_HIGH) && half_done && last_bit;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // Writes that find the buffer full are dropped; data_wr_ready warns first.
  assign tx_push = data_wr && ctl_ff.master_enable_bit && data_wr_ready_ff;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) tx_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(data_wdata),
    .in_valid(tx_push),
    .in_ready(),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(load_byte)
  );

  // ----------------------------------------------------------------
  // Control next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctl = ctl_ff;
    if (ctl_wr) begin
      nxt_ctl.transfer_complete_flag = ctl_wdata[`CTL_FLAG_BIT];
      nxt_ctl.master_enable_bit = ctl_wdata[`CTL_MASTER_BIT];
      nxt_ctl.mode_fault_flag = ctl_wdata[`CTL_FAULT_BIT];
      nxt_ctl.select_mode_hi = ctl_wdata[`CTL_SEL_HI_BIT];
      nxt_ctl.select_mode_lo = ctl_wdata[`CTL_SEL_LO_BIT];
      nxt_ctl.port_enable_bit = ctl_wdata[`CTL_ENABLE_BIT];
    end
    if (byte_done) begin
      nxt_ctl.transfer_complete_flag = 1'b1;
    end
    if (fault_hit) begin
      nxt_ctl.master_enable_bit = 1'b0;
      nxt_ctl.port_enable_bit = 1'b0;
      nxt_ctl.mode_fault_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_div = div_ff;
    nxt_pins = pins_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_div = 8'h00;
        nxt_bit_cnt = 4'h0;
        nxt_pins.sck = 1'b0;
        if (load_byte) begin
          nxt_shift = fifo_data;
          nxt_pins.mosi = fifo_data[7];
          nxt_state = ST_LOW;
        end
      end
      ST_LOW: begin
        nxt_div = half_done ? 8'h00 : div_ff + 8'h01;
        if (half_done) begin
          nxt_pins.sck = 1'b1;
          nxt_shift = {shift_ff[6:0], miso};
          nxt_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        nxt_div = half_done ? 8'h00 : div_ff + 8'h01;
        if (half_done) begin
          nxt_pins.sck = 1'b0;
          nxt_pins.mosi = shift_ff[7];
          nxt_bit_cnt = bit_cnt_ff + 4'h1;
          nxt_state = last_bit ? ST_IDLE : ST_LOW;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Losing the bus mid-byte stops the clock at once to avoid contention.
    if (fault_hit || !master_on) begin
      nxt_state = ST_IDLE;
      nxt_pins.sck = 1'b0;
    end
    nxt_pins.sel_oe = nxt_ctl.select_mode_hi;
    nxt_pins.sel_out = nxt_ctl.select_mode_lo;
  end

  // ----------------------------------------------------------------
  // Transmit buffer occupancy
  // ----------------------------------------------------------------
  // The count mirrors the FIFO so that data_wr_ready can come from a flop.
  assign nxt_level = level_ff + LVL_W'(tx_push) - LVL_W'(load_byte);
  assign nxt_ready = nxt_level != LVL_W'(FIFO_DEPTH);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= '0;
      data_wr_ready_ff <= 1'b1;
    end else begin
      level_ff <= nxt_level;
      data_wr_ready_ff <= nxt_ready;
    end
  end

  // ----------------------------------------------------------------
  // Control register state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff.transfer_complete_flag <= CTL_RESET_W[`CTL_FLAG_BIT];
      ctl_ff.master_enable_bit <= CTL_RESET_W[`CTL_MASTER_BIT];
      ctl_ff.mode_fault_flag <= CTL_RESET_W[`CTL_FAULT_BIT];
      ctl_ff.select_mode_hi <= CTL_RESET_W[`CTL_SEL_HI_BIT];
      ctl_ff.select_mode_lo <= CTL_RESET_W[`CTL_SEL_LO_BIT];
      ctl_ff.port_enable_bit <= CTL_RESET_W[`CTL_ENABLE_BIT];
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Loading from the next value keeps the readback in step with ctl_ff.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_rdata_ff <= CTL_RESET_W;
    end else begin
      ctl_rdata_ff <= nxt_ctl_bits;
    end
  end

  // ----------------------------------------------------------------
  // Shift registers and serial pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      shift_ff <= '0;
      bit_cnt_ff <= '0;
      div_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      div_ff <= nxt_div;
    end
  end

  assign nxt_drive_oe = nxt_ctl.master_enable_bit &&
                        nxt_ctl.port_enable_bit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_ff.sck <= 1'b0;
      pins_ff.mosi <= 1'b0;
      pins_ff.sel_out <= CTL_RESET_W[`CTL_SEL_LO_BIT];
      pins_ff.sel_oe <= CTL_RESET_W[`CTL_SEL_HI_BIT];
      drive_oe_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      drive_oe_ff <= nxt_drive_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ff <= '0;
    end else if (byte_done) begin
      rx_ff <= shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and outputs
  // ----------------------------------------------------------------
  // done or mode fault interrupt
  assign nxt_irq = irq_enable &&
                   (nxt_ctl.transfer_complete_flag || nxt_ctl.mode_fault_flag);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Every output below is a plain copy of a flop.
  assign ctl_rdata = ctl_rdata_ff;
  assign data_wr_ready = data_wr_ready_ff;
  assign rx_data = rx_ff;
  assign irq = irq_ff;
  assign sck = pins_ff.sck;
  assign sck_oe = drive_oe_ff;
  assign mosi = pins_ff.mosi;
  assign mosi_oe = drive_oe_ff;
  assign slave_select_out = pins_ff.sel_out;
  assign slave_select_oe = pins_ff.sel_oe;

endmodule // spi_master_engine

// ---- test/spi_master_engine_chk.sv ----
// Concurrent checks on the pins of the serial port engine.
`timescale 1ns/1ps
module spi_master_engine_chk #(
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] HALF_CYCLES = 8'h02
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic ctl_wr, // control write strobe
  input wire logic [7:0] ctl_rdata, // control contents
  input wire logic irq_enable, // interrupt enable
  input wire logic irq, // interrupt request
  input wire logic slave_select_in, // select pin level
  input wire logic slave_select_out, // select drive value
  input wire logic slave_select_oe // select drive enable
);
  // ----------------------------------------------------------------
  // Flag and select checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence contested;
    ctl_rdata[3:2] == 2'b01 && ctl_rdata[6] && ctl_rdata[0] &&
    !slave_select_in && !ctl_wr;
  endsequence
  sequence knocked_out;
    ctl_rdata[5] && !ctl_rdata[6] && !ctl_rdata[0];
  endsequence
  fault_sets_a: assert property (contested |-> ##[1:4] knocked_out)
    else $error("mode fault did not disable the master");
  fault_irq_a: assert property ($rose(ctl_rdata[5]) && irq_enable |-> ##[0:1] irq)
    else $error("mode fault raised no interrupt");
  flag_irq_a: assert property ($rose(ctl_rdata[7]) && irq_enable |-> ##[0:1] irq)
    else $error("transfer done raised no interrupt");
  flag_hold_a: assert property (ctl_rdata[7] && !ctl_wr |=> ctl_rdata[7])
    else $error("done flag cleared by hardware");
  fault_hold_a: assert property (ctl_rdata[5] && !ctl_wr |=> ctl_rdata[5])
    else $error("fault flag cleared by hardware");
  no_reenable_a: assert property (!ctl_rdata[6] && !ctl_wr |=> !ctl_rdata[6])
    else $error("master mode came back without a write");
  four_wire_a: assert property (ctl_rdata[3] && $stable(ctl_rdata[3:2])
    |-> slave_select_oe && slave_select_out == ctl_rdata[2])
    else $error("select output does not follow its bit");
  select_input_a: assert property (!ctl_rdata[3] && $stable(ctl_rdata[3])
    |-> !slave_select_oe)
    else $error("select pin driven outside four wire mode");
endmodule // spi_master_engine_chk

bind spi_master_engine spi_master_engine_chk #(
  .FIFO_DEPTH(FIFO_DEPTH), .HALF_CYCLES(HALF_CYCLES)
) i_chk (.clk, .rst_n, .ctl_wr, .ctl_rdata, .irq_enable, .irq,
  .slave_select_in, .slave_select_out, .slave_select_oe);

// ---- test/spi_slave_model.sv ----
// Behavioural slave that answers every byte with the same reply byte.
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic sck, // serial clock from the master
  input wire logic sel_n, // slave select, active low
  input wire logic [7:0] reply, // byte returned for each transfer
  output logic miso // serial data back to the master
);
  logic [7:0] sr_ff;
  logic armed = 1'b0;
  int bits = 0;
  initial #1 sr_ff = reply;
  // The reset step from unknown to low is no clock, so only a fall that
  // follows a rise counts.
  always @(posedge sck) armed = 1'b1;
  always @(negedge sck) begin
    if (armed) begin
      armed = 1'b0;
      bits = bits + 1;
      if (bits == 8) begin
        bits = 0;
        sr_ff = reply;
      end else begin
        sr_ff = {sr_ff[6:0], ~sr_ff[0]};
      end
    end
  end
  // A released line shows the opposite level so stale data never passes.
  assign miso = sel_n ? ~sr_ff[7] : sr_ff[7];
endmodule // spi_slave_model

// ---- test/tb_spi_master_engine.sv ----
// Self-checking bench for the serial port master engine.
`timescale 1ns/1ps
module tb_spi_master_engine;
  logic clk = 1'b0, rst_n = 1'b0, ctl_wr = 1'b0, data_wr = 1'b0;
  logic irq_enable = 1'b0, other_n = 1'b1;
  logic [7:0] ctl_wdata = 8'h00, data_wdata = 8'h00, mosi_sr = 8'h00;
  logic [7:0] ctl_rdata, rx_data;
  logic data_wr_ready, irq, sck, mosi, miso, ssel_in, ssel_out, ssel_oe;
  logic sck_oe, mosi_oe;
  int n_fail = 0, n_tests = 0, n_sck = 0;
  spi_master_engine i_dut (.clk, .rst_n, .ctl_wr, .ctl_wdata, .ctl_rdata,
    .data_wr, .data_wdata, .data_wr_ready, .rx_data, .irq_enable, .irq,
    .sck, .sck_oe, .mosi, .mosi_oe, .miso, .slave_select_in(ssel_in),
    .slave_select_out(ssel_out), .slave_select_oe(ssel_oe));
  // unselected modes use a GPIO select held low
  spi_slave_model i_slave (.sck, .sel_n(ssel_oe ? ssel_out : 1'b0),
    .reply(8'ha3), .miso);
  // Another master pulls the shared select low through other_n.
  assign ssel_in = ssel_oe ? ssel_out : other_n;
  initial forever #20 clk = ~clk;
  always @(posedge sck) begin
    mosi_sr <= {mosi_sr[6:0], mosi};
    n_sck <= n_sck + 1;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wctl(input logic [7:0] v);
    @(posedge clk) ctl_wr <= 1'b1;
    ctl_wdata <= v;
    @(posedge clk) ctl_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task wait_done(input int bits);
    for (int i = 0; i < 3000 && n_sck < bits; i++) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task fill_and_drain;
    int n;
    n = 0;
    wctl(8'h4d);
    check("sel_hi", {6'h0, ssel_oe, ssel_out}, 8'h03);
    wctl(8'h49);
    check("sel_lo", {6'h0, ssel_oe, ssel_out}, 8'h02);
    data_wr <= 1'b1;
    data_wdata <= 8'h10;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      if (!data_wr_ready) break;
      n++;
      data_wdata <= 8'h10 + 8'(n);
    end
    data_wr <= 1'b0;
    check("fill", {7'h0, n == 8 || n == 9}, 8'h01);
    wait_done(n * 8);
    check("sck_count", 8'(n_sck), 8'(n * 8));
    check("mosi_last", mosi_sr, 8'h10 + 8'(n - 1));
    check("rx", rx_data, 8'ha3);
    check("done_masked", {6'h0, ctl_rdata[7], irq}, 8'h02);
    irq_enable <= 1'b1;
    repeat (2) @(posedge clk);
    check("irq", {7'h0, irq}, 8'h01);
    wctl(8'h49);
    check("cleared", {6'h0, ctl_rdata[7], irq}, 8'h00);
  endtask
  task three_wire;
    int base;
    wctl(8'h41);
    check("oe3", {7'h0, ssel_oe}, 8'h00);
    check("drive_oe", {6'h0, sck_oe, mosi_oe}, 8'h03);
    base = n_sck;
    data_wr <= 1'b1;
    data_wdata <= 8'h96;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (data_wr_ready) break;
    end
    data_wr <= 1'b0;
    wait_done(base + 8);
    check("sck3", 8'(n_sck - base), 8'h08);
    check("mosi3", mosi_sr, 8'h96);
    check("rx3", rx_data, 8'ha3);
    check("irq3", {6'h0, ctl_rdata[7], irq}, 8'h03);
    wctl(8'h04);
  endtask
  task mode_fault;
    wctl(8'h45);
    other_n <= 1'b0;
    repeat (3) @(posedge clk);
    other_n <= 1'b1;
    repeat (20) @(posedge clk);
    check("fault", ctl_rdata & 8'h61, 8'h20);
    check("drive_off", {6'h0, sck_oe, mosi_oe}, 8'h00);
    check("fault_irq", {7'h0, irq}, 8'h01);
    wctl(8'h04);
    check("fault_clr", {7'h0, irq}, 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("reset", ctl_rdata, 8'h04);
    fill_and_drain;
    three_wire;
    mode_fault;
    tally_and_finish;
  end
endmodule // tb_spi_master_engine
